// ==== rtl/isr_params.svh ====
// Purpose: constants for the indirect store and return execution block
// Assumes: included by the package and by every design file that needs it
// Notes: APB byte offsets, instruction word fields, reset values
//
// Summary of operation
// - Indirect store writes W to the address held in file pointer 0 or 1.
// - Mode code picks pre-increment, pre-decrement, post-increment or post-decrement.
// - Offset form stores at pointer plus k (-32..31); pointer stays unchanged.
// - File pointers are 16 bits and wrap modulo 2^16 on step.
// - Indirect store and its pointer step change no status flag.
// - Indirect windows hold no storage; writes go to the pointer address, reads return zero.
// - Option load copies W to option register, one cycle, no flag change.
// - Software reset resets the device and clears the reset instruction flag.
// - Interrupt return pops stack into PC, sets enable bit 7, two cycles.
// - Subroutine return pops stack into PC, two cycles, flags unchanged.
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH

`define ISR_OFF_INSN 8'h00
`define ISR_OFF_W 8'h04
`define ISR_OFF_FP0 8'h08
`define ISR_OFF_FP1 8'h0c
`define ISR_OFF_OPT 8'h10
`define ISR_OFF_STAT 8'h14
`define ISR_OFF_PWRCTL 8'h18
`define ISR_OFF_PC 8'h1c
`define ISR_OFF_IRQ 8'h20
`define ISR_OFF_WIN0 8'h24
`define ISR_OFF_WIN1 8'h28

`define ISR_F_OP 2:0
`define ISR_F_N 3
`define ISR_F_MODE 5:4
`define ISR_F_OFS 6
`define ISR_F_K 13:8
`define ISR_F_BUSY 0
`define ISR_F_RST_FLAG 0

`define ISR_MODE_PREINC 2'h0
`define ISR_MODE_PREDEC 2'h1
`define ISR_MODE_POSTINC 2'h2
`define ISR_MODE_POSTDEC 2'h3

`define ISR_IRQ_EN_BIT 7
`define ISR_W_RST 8'h00
`define ISR_OPT_RST 8'hff
`define ISR_STAT_RST 8'h00
`define ISR_FP_RST 16'h0000
`define ISR_PC_RST 15'h0000
`define ISR_IRQ_RST 8'h00
`define ISR_RST_FLAG_RST 1'b1
`define ISR_PC_STEP 15'h0001

`endif

// ==== rtl/isr_pkg.sv ====
// Purpose: shared types of the indirect store and return block
// Assumes: isr_params.svh supplies the constants
// Notes: state codes are Gray along idle, execute, second cycle
`include "isr_params.svh"
package isr_pkg;
   typedef enum logic [1:0] {
      ISR_IDLE = 2'h0,
      ISR_EXEC = 2'h1,
      ISR_SECOND = 2'h3
   } isr_state_t;

   typedef enum logic [2:0] {
      ISR_OP_NOP = 3'h0,
      ISR_OP_STORE_W = 3'h1,
      ISR_OP_OPTION = 3'h2,
      ISR_OP_RESET = 3'h3,
      ISR_OP_IRQ_RET = 3'h4,
      ISR_OP_RETURN = 3'h5
   } isr_op_t;

   typedef struct packed {
      isr_state_t st;
      logic [13:0] insn;
      logic [7:0] w;
      logic [1:0][15:0] fp;
      logic [7:0] opt;
      logic [7:0] stat;
      logic [7:0] irq;
      logic reset_insn_flag;
      logic [14:0] pc;
      logic mem_we;
      logic [15:0] mem_addr;
      logic [7:0] mem_wdata;
      logic pop;
      logic soft_rst;
      logic [31:0] prdata;
      logic was_idle;
   } isr_regs_t;
endpackage : isr_pkg

// ==== rtl/isr_ptr_calc.sv ====
// Purpose: effective address and next pointer value for indirect stores
// Assumes: pure combinational, pointer and offset widths are parameters
// Notes: sums are cut to the pointer width, so stepping wraps
`timescale 1ns/100ps
`include "isr_params.svh"
module isr_ptr_calc #(
   parameter int AW = 16,
   parameter int KW = 6
) (
   input wire logic [AW-1:0] fp, // Current pointer
   input wire logic [1:0] ptr_mode_code, // Step mode code
   input wire logic ofs_form, // Signed offset form
   input wire logic [KW-1:0] k, // Signed offset
   output logic [AW-1:0] eff_addr, // Address of the access
   output logic [AW-1:0] fp_next // Pointer after the access
);
   logic [AW-1:0] step;
   logic [AW-1:0] stepped;
   logic [AW-1:0] k_ext;

   always_comb begin
      step = AW'(1);
      if (ptr_mode_code == `ISR_MODE_PREDEC || ptr_mode_code == `ISR_MODE_POSTDEC) begin
         step = '1;
      end
      stepped = AW'(fp + step);
      k_ext = {{(AW-KW){k[KW-1]}}, k};
      if (ofs_form) begin
         eff_addr = AW'(fp + k_ext);
         fp_next = fp;
      end else begin
         // Pre modes use the stepped value, post modes the old one
         if (ptr_mode_code == `ISR_MODE_PREINC || ptr_mode_code == `ISR_MODE_PREDEC) begin
            eff_addr = stepped;
         end else begin
            eff_addr = fp;
         end
         fp_next = stepped;
      end
   end
endmodule : isr_ptr_calc

// ==== rtl/isr_core.sv ====
// Purpose: executes store-indirect, no-op, option load, software reset and returns
// Assumes: APB3 slave at 125 MHz; one instruction cycle is one pclk
// Notes: data memory and stack live outside; this block drives their ports
`timescale 1ns/100ps
`include "isr_params.svh"
module isr_core
   import isr_pkg::*;
#(
   parameter int AW = 16,
   parameter int PCW = 15
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [PCW-1:0] stack_top, // Top of hardware stack
   output logic stack_pop, // Pop strobe
   output logic mem_we, // Data memory write strobe
   output logic [AW-1:0] mem_addr, // Data memory address
   output logic [7:0] mem_wdata, // Data memory write data
   output logic soft_reset // Device reset request
);
   isr_regs_t st_q;
   isr_regs_t st_d;
   isr_op_t op;
   logic n_sel;
   logic [AW-1:0] sel_fp;
   logic [AW-1:0] eff_addr;
   logic [AW-1:0] fp_next;
   logic acc;
   logic wr;
   logic mapped;
   logic bad_op;
   logic [31:0] rd_mux;

   assign op = isr_op_t'(st_q.insn[`ISR_F_OP]);
   assign n_sel = st_q.insn[`ISR_F_N];
   assign sel_fp = st_q.fp[n_sel];

   isr_ptr_calc #(.AW(AW), .KW(6)) u_ptr (
      .fp(sel_fp),
      .ptr_mode_code(st_q.insn[`ISR_F_MODE]),
      .ofs_form(st_q.insn[`ISR_F_OFS]),
      .k(st_q.insn[`ISR_F_K]),
      .eff_addr(eff_addr),
      .fp_next(fp_next)
   );

   // Reads wait one idle cycle so prdata never shows pre-execute values
   assign pready = (st_q.st == ISR_IDLE) && st_q.was_idle;
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `ISR_OFF_INSN: rd_mux = {18'h0_0000, st_q.insn};
         `ISR_OFF_W: rd_mux = {24'h00_0000, st_q.w};
         `ISR_OFF_FP0: rd_mux = {16'h0000, st_q.fp[0]};
         `ISR_OFF_FP1: rd_mux = {16'h0000, st_q.fp[1]};
         `ISR_OFF_OPT: rd_mux = {24'h00_0000, st_q.opt};
         `ISR_OFF_STAT: rd_mux = {24'h00_0000, st_q.stat};
         `ISR_OFF_PWRCTL: rd_mux = {31'h0000_0000, st_q.reset_insn_flag};
         `ISR_OFF_PC: rd_mux = {17'h0_0000, st_q.pc};
         `ISR_OFF_IRQ: rd_mux = {24'h00_0000, st_q.irq};
         `ISR_OFF_WIN0: rd_mux = 32'h0000_0000;
         `ISR_OFF_WIN1: rd_mux = 32'h0000_0000;
         default: mapped = 1'b0;
      endcase
   end

   assign bad_op = (paddr == `ISR_OFF_INSN) && pwrite && (pwdata[`ISR_F_OP] > 3'h5);
   assign pslverr = acc && (!mapped || bad_op);

   always_comb begin
      st_d = st_q;
      st_d.mem_we = 1'b0;
      st_d.pop = 1'b0;
      st_d.soft_rst = 1'b0;
      st_d.was_idle = (st_q.st == ISR_IDLE);
      st_d.prdata = psel ? rd_mux : st_q.prdata;
      case (st_q.st)
         ISR_IDLE: begin
            if (wr && mapped && !bad_op) begin
               case (paddr)
                  `ISR_OFF_INSN: begin
                     st_d.insn = pwdata[13:0];
                     st_d.st = ISR_EXEC;
                  end
                  `ISR_OFF_W: st_d.w = pwdata[7:0];
                  `ISR_OFF_FP0: st_d.fp[0] = pwdata[15:0];
                  `ISR_OFF_FP1: st_d.fp[1] = pwdata[15:0];
                  `ISR_OFF_STAT: st_d.stat = pwdata[7:0];
                  `ISR_OFF_PWRCTL: st_d.reset_insn_flag = pwdata[`ISR_F_RST_FLAG];
                  `ISR_OFF_IRQ: st_d.irq = pwdata[7:0];
                  `ISR_OFF_WIN0: begin
                     // No window storage: the write lands at the pointer address
                     st_d.mem_we = 1'b1;
                     st_d.mem_addr = st_q.fp[0];
                     st_d.mem_wdata = pwdata[7:0];
                  end
                  `ISR_OFF_WIN1: begin
                     st_d.mem_we = 1'b1;
                     st_d.mem_addr = st_q.fp[1];
                     st_d.mem_wdata = pwdata[7:0];
                  end
                  default: st_d.st = ISR_IDLE;
               endcase
            end
         end
         ISR_EXEC: begin
            st_d.st = ISR_IDLE;
            st_d.pc = PCW'(st_q.pc + `ISR_PC_STEP);
            case (op)
               ISR_OP_STORE_W: begin
                  st_d.mem_we = 1'b1;
                  st_d.mem_addr = eff_addr;
                  st_d.mem_wdata = st_q.w;
                  st_d.fp[n_sel] = fp_next;
               end
               ISR_OP_OPTION: st_d.opt = st_q.w;
               ISR_OP_RESET: begin
                  // Registers return to power-up values, except the cause flag, which clears, and insn, mem_addr, mem_wdata and prdata, which keep theirs
                  st_d.w = `ISR_W_RST;
                  st_d.fp = {`ISR_FP_RST, `ISR_FP_RST};
                  st_d.opt = `ISR_OPT_RST;
                  st_d.stat = `ISR_STAT_RST;
                  st_d.irq = `ISR_IRQ_RST;
                  st_d.pc = `ISR_PC_RST;
                  st_d.reset_insn_flag = 1'b0;
                  st_d.soft_rst = 1'b1;
               end
               ISR_OP_IRQ_RET: begin
                  st_d.pop = 1'b1;
                  st_d.pc = stack_top;
                  st_d.irq[`ISR_IRQ_EN_BIT] = 1'b1;
                  st_d.st = ISR_SECOND;
               end
               ISR_OP_RETURN: begin
                  st_d.pop = 1'b1;
                  st_d.pc = stack_top;
                  st_d.st = ISR_SECOND;
               end
               default: st_d.st = ISR_IDLE;
            endcase
         end
         ISR_SECOND: st_d.st = ISR_IDLE;
         default: st_d.st = ISR_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '{st: ISR_IDLE, insn: 14'h0000, w: `ISR_W_RST,
                   fp: {`ISR_FP_RST, `ISR_FP_RST}, opt: `ISR_OPT_RST,
                   stat: `ISR_STAT_RST, irq: `ISR_IRQ_RST,
                   reset_insn_flag: `ISR_RST_FLAG_RST,
                   pc: `ISR_PC_RST, mem_we: 1'b0, mem_addr: 16'h0000,
                   mem_wdata: 8'h00, pop: 1'b0, soft_rst: 1'b0,
                   prdata: 32'h0000_0000, was_idle: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.prdata;
   assign stack_pop = st_q.pop;
   assign mem_we = st_q.mem_we;
   assign mem_addr = st_q.mem_addr;
   assign mem_wdata = st_q.mem_wdata;
   assign soft_reset = st_q.soft_rst;

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_exec(isr_op_t o);
      st_q.st == ISR_EXEC && op == o;
   endsequence

   sequence s_store(logic [1:0] m, logic f);
      s_exec(ISR_OP_STORE_W) ##0 st_q.insn[`ISR_F_MODE] == m && st_q.insn[`ISR_F_OFS] == f;
   endsequence

   sequence s_ret_tail;
      st_q.st == ISR_SECOND ##1 st_q.st == ISR_IDLE;
   endsequence

   AST_STORE_DATA: assert property (s_exec(ISR_OP_STORE_W) |=>
      mem_we && mem_wdata == $past(st_q.w))
      else $error("store did not write W");

   AST_PREINC: assert property (s_store(`ISR_MODE_PREINC, 1'b0) |=>
      mem_addr == AW'($past(sel_fp) + AW'(1)) && st_q.fp[$past(n_sel)] == mem_addr)
      else $error("pre-increment address wrong");

   AST_POSTDEC: assert property (s_store(`ISR_MODE_POSTDEC, 1'b0) |=>
      mem_addr == $past(sel_fp) && st_q.fp[$past(n_sel)] == AW'(mem_addr - AW'(1)))
      else $error("post-decrement pointer wrong");

   AST_OFS_KEEP: assert property (s_exec(ISR_OP_STORE_W) ##0 st_q.insn[`ISR_F_OFS] |=>
      st_q.fp == $past(st_q.fp) && mem_addr == AW'($past(sel_fp)
      + {{(AW-6){$past(st_q.insn[13])}}, $past(st_q.insn[`ISR_F_K])}))
      else $error("offset store moved pointer");

   AST_WRAP: assert property (s_store(`ISR_MODE_POSTINC, 1'b0) ##0 sel_fp == '1 |=>
      st_q.fp[$past(n_sel)] == '0)
      else $error("pointer did not wrap");

   AST_STAT_HOLD: assert property (st_q.st == ISR_EXEC && op != ISR_OP_RESET |=>
      $stable(st_q.stat))
      else $error("status changed by instruction");

   AST_WINDOW: assert property (wr && paddr == `ISR_OFF_WIN1 |=>
      mem_we && mem_addr == $past(st_q.fp[1]))
      else $error("window write not redirected");

   AST_OPTION: assert property (s_exec(ISR_OP_OPTION) |=>
      st_q.opt == $past(st_q.w) && st_q.st == ISR_IDLE)
      else $error("option load wrong");

   AST_SWRESET: assert property (s_exec(ISR_OP_RESET) |=>
      soft_reset && !st_q.reset_insn_flag && st_q.pc == `ISR_PC_RST ##1 !soft_reset)
      else $error("software reset wrong");

   AST_IRQ_RET: assert property (s_exec(ISR_OP_IRQ_RET) |=>
      stack_pop && st_q.pc == $past(stack_top) && st_q.irq[`ISR_IRQ_EN_BIT] ##0 s_ret_tail)
      else $error("interrupt return wrong");

   AST_RETURN: assert property (s_exec(ISR_OP_RETURN) |=>
      stack_pop && st_q.pc == $past(stack_top) && $stable(st_q.irq) ##0 s_ret_tail)
      else $error("subroutine return wrong");

   AST_NOP: assert property (s_exec(ISR_OP_NOP) |=>
      st_q.pc == PCW'($past(st_q.pc) + `ISR_PC_STEP) && $stable(st_q.w)
      && $stable(st_q.fp) && !mem_we && st_q.st == ISR_IDLE)
      else $error("no-op changed state");
endmodule : isr_core

// ==== sim/isr_core_tb.sv ====
// Purpose: self-checking bench for the indirect store and return block
// Assumes: APB master tasks, outputs sampled at the falling edge where settled
// Notes: no separate partner; the bench drives stack_top itself
`timescale 1ns/100ps
`include "isr_params.svh"
module isr_core_tb;
   import isr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, stack_pop, mem_we, soft_reset, perr;
   logic [14:0] stack_top;
   logic [15:0] mem_addr, seen_addr;
   logic [7:0] mem_wdata, seen_data;
   int err_total, cmp_count, pops, resets, writes;

   isr_core #(.AW(16), .PCW(15)) u_isr_core (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stack_top(stack_top),
      .stack_pop(stack_pop), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .soft_reset(soft_reset)
   );

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Pulses are registered, so the falling edge sees each exactly once
   always @(negedge pclk) begin
      if (mem_we === 1'b1) begin
         writes++;
         seen_addr = mem_addr;
         seen_data = mem_wdata;
      end
      if (stack_pop === 1'b1) pops++;
      if (soft_reset === 1'b1) resets++;
   end

   task automatic tally_and_finish();
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Request held until the rising edge that samples pready high, then one idle edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_total++;
         $display("mismatch pready expected 1 seen %b", pready);
         tally_and_finish();
      end
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rdchk

   task automatic op(input logic [2:0] code);
      apb(1'b1, `ISR_OFF_INSN, {29'h0, code});
   endtask : op

   task automatic store(input logic n, input logic [1:0] mode, input logic ofs,
         input logic [5:0] k, input logic [15:0] f);
      logic [15:0] ea, fn;
      int w0;
      ea = ofs ? f + {{10{k[5]}}, k} : (mode[1] ? f : (mode[0] ? f - 16'h1 : f + 16'h1));
      fn = ofs ? f : (mode[0] ? f - 16'h1 : f + 16'h1);
      apb(1'b1, n ? `ISR_OFF_FP1 : `ISR_OFF_FP0, {16'h0, f});
      w0 = writes;
      apb(1'b1, `ISR_OFF_INSN, {18'h0, k, 1'b0, ofs, mode, n, 3'h1});
      rdchk("pointer after", n ? `ISR_OFF_FP1 : `ISR_OFF_FP0, {16'h0, fn});
      chk("store strobes", 32'h1, 32'(writes - w0));
      chk("store address", {16'h0, ea}, {16'h0, seen_addr});
      chk("store data", 32'h5a, {24'h0, seen_data});
   endtask : store

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      stack_top = 15'h0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk("option reset", `ISR_OFF_OPT, 32'hff);
      rdchk("power control reset", `ISR_OFF_PWRCTL, 32'h1);
      rdchk("pc reset", `ISR_OFF_PC, 32'h0);
      $display("test reset values done");

      apb(1'b1, `ISR_OFF_W, 32'h5a);
      apb(1'b1, `ISR_OFF_STAT, 32'h07);
      for (int i = 0; i < 4; i++) begin
         store(1'b0, i[1:0], 1'b0, 6'h00, 16'h0010);
      end
      store(1'b1, 2'h2, 1'b0, 6'h00, 16'hffff);
      store(1'b1, 2'h3, 1'b0, 6'h00, 16'h0000);
      store(1'b1, 2'h0, 1'b1, 6'h20, 16'h0100);
      store(1'b0, 2'h2, 1'b1, 6'h1f, 16'hfff0);
      rdchk("status after stores", `ISR_OFF_STAT, 32'h07);
      rdchk("pc after stores", `ISR_OFF_PC, 32'h8);
      $display("test indirect stores done");

      apb(1'b1, `ISR_OFF_WIN1, 32'h33);
      chk("window address", 32'h0100, {16'h0, seen_addr});
      chk("window data", 32'h33, {24'h0, seen_data});
      rdchk("window read", `ISR_OFF_WIN1, 32'h0);
      $display("test window done");

      op(3'h0);
      rdchk("pc after nop", `ISR_OFF_PC, 32'h9);
      rdchk("w after nop", `ISR_OFF_W, 32'h5a);
      apb(1'b1, `ISR_OFF_W, 32'h4f);
      op(3'h2);
      rdchk("option load", `ISR_OFF_OPT, 32'h4f);
      rdchk("status after option", `ISR_OFF_STAT, 32'h07);
      $display("test nop and option done");

      stack_top <= 15'h1234;
      op(3'h5);
      rdchk("pc after return", `ISR_OFF_PC, 32'h1234);
      rdchk("irq after return", `ISR_OFF_IRQ, 32'h0);
      rdchk("status after return", `ISR_OFF_STAT, 32'h07);
      stack_top <= 15'h2abc;
      op(3'h4);
      rdchk("pc after irq return", `ISR_OFF_PC, 32'h2abc);
      rdchk("enable after irq return", `ISR_OFF_IRQ, 32'h80);
      chk("pops", 32'h2, 32'(pops));
      $display("test returns done");

      op(3'h3);
      rdchk("power control after reset", `ISR_OFF_PWRCTL, 32'h0);
      chk("reset pulses", 32'h1, 32'(resets));
      rdchk("option after reset", `ISR_OFF_OPT, 32'hff);
      rdchk("irq after reset", `ISR_OFF_IRQ, 32'h0);
      $display("test software reset done");

      apb(1'b1, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, perr});
      op(3'h6);
      chk("bad opcode error", 32'h1, {31'h0, perr});
      rdchk("pc after bad opcode", `ISR_OFF_PC, 32'h0);
      $display("test refusals done");
      tally_and_finish();
   end
endmodule : isr_core_tb
